// >>> design/vrc_regs.vh
`ifndef VRC_REGS_VH
`define VRC_REGS_VH

// register byte offsets
`define VRC_OFS_IRQ_STAT 12'h000
`define VRC_OFS_FAST_STAT 12'h004
`define VRC_OFS_RAW_STAT 12'h008
`define VRC_OFS_ENABLE 12'h00c
`define VRC_OFS_SELECT 12'h010
`define VRC_OFS_SOFT 12'h014
`define VRC_OFS_VECT_ADDR 12'h030
`define VRC_OFS_DEF_ADDR 12'h034
// slot banks: upper offset nibble, slot number in offset bits 5:2
`define VRC_OFS_SLOT_ADDR 4'h1
`define VRC_OFS_SLOT_CTRL 4'h2

// slot control fields
`define VRC_SLOT_SRC_LSB 0
`define VRC_SLOT_SRC_MSB 4
`define VRC_SLOT_EN_BIT 5

// reset values
`define VRC_RST_ENABLE 32'h0000_0000
`define VRC_RST_SELECT 32'h0000_0000
`define VRC_RST_SOFT 32'h0000_0000
`define VRC_RST_DEF_ADDR 32'h0000_0000
`define VRC_RST_SLOT_ADDR 32'h0000_0000
`define VRC_RST_SLOT_CTRL 6'h00

// channel numbers
`define VRC_CH_WATCHDOG 0
`define VRC_CH_SOFT_ONLY 1
`define VRC_CH_DBG_RX 2
`define VRC_CH_DBG_TX 3
`define VRC_CH_TIMER0 4
`define VRC_CH_TIMER1 5
`define VRC_CH_SERIAL0 6
`define VRC_CH_SERIAL1 7
`define VRC_CH_PWM 8
`define VRC_CH_TWI 9
`define VRC_CH_SYNC0 10
`define VRC_CH_SYNC1 11
`define VRC_CH_PLL 12
`define VRC_CH_RTC 13
`define VRC_CH_EXT0 14
`define VRC_CH_ADC 18
`define VRC_CH_CAN_FILT 19
`define VRC_CH_CAN0 20

`endif

// >>> design/vrc_prio.v
`timescale 1ns/1ps
// fixed-priority pick over the vectored slots, lowest index wins
module vrc_prio #(
    parameter NSLOT = 16,
    parameter IW = 4
) (
    input wire [NSLOT-1:0] slot_req,
    output reg hit,
    output reg [IW-1:0] idx
);
    integer i;

    always @* begin
        hit = 1'b0;
        idx = {IW{1'b0}};
        // scan downwards so the lowest requesting slot is left last
        for (i = NSLOT - 1; i >= 0; i = i - 1) begin
            if (slot_req[i]) begin
                hit = 1'b1;
                idx = i[IW-1:0];
            end
        end
    end
endmodule // vrc_prio

// >>> design/vrc_ctrl.v
`timescale 1ns/1ps
`include "vrc_regs.vh"
module vrc_ctrl #(
    parameter NCH = 32,
    parameter NSLOT = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire watchdog_flag,
    input wire debug_comm_receive,
    input wire debug_comm_transmit,
    input wire timer0_request,
    input wire timer1_request,
    input wire serial0_request,
    input wire serial1_request,
    input wire pwm_request,
    input wire twi_request,
    input wire sync0_request,
    input wire sync1_request,
    input wire pll_locked_flag,
    input wire rtc_request,
    input wire external_irq_zero,
    input wire external_irq_one,
    input wire external_irq_two,
    input wire external_irq_three,
    input wire adc_request,
    input wire can_filter_request,
    input wire [3:0] can_tx_request,
    input wire [3:0] can_rx_request,
    output reg fast_request_out,
    output reg normal_request_out
);
    localparam SIW = 4;

    reg [31:0] enable_r;
    reg [31:0] select_r;
    reg [31:0] soft_r;
    reg [31:0] def_addr_r;
    reg [31:0] slot_addr_r [0:NSLOT-1];
    reg [5:0] slot_ctrl_r [0:NSLOT-1];
    reg wr_pend_r;
    reg [11:0] wr_addr_r;
    reg [31:0] rdata_nxt;
    reg we_enable;
    reg we_select;
    reg we_soft;
    reg we_def_addr;
    reg we_slot_addr;
    reg we_slot_ctrl;

    wire [NCH-1:0] hw_src;
    wire [31:0] raw_req;
    wire [31:0] fast_stat;
    wire [31:0] norm_stat;
    wire [NSLOT-1:0] slot_req;
    wire slot_hit;
    wire [SIW-1:0] slot_idx;
    wire [31:0] vect_addr;
    wire addr_ok;
    wire [11:0] a_ofs;

    assign hw_src[`VRC_CH_WATCHDOG] = watchdog_flag;
    assign hw_src[`VRC_CH_SOFT_ONLY] = 1'b0;
    assign hw_src[`VRC_CH_DBG_RX] = debug_comm_receive;
    assign hw_src[`VRC_CH_DBG_TX] = debug_comm_transmit;
    assign hw_src[`VRC_CH_TIMER0] = timer0_request;
    assign hw_src[`VRC_CH_TIMER1] = timer1_request;
    assign hw_src[`VRC_CH_SERIAL0] = serial0_request;
    assign hw_src[`VRC_CH_SERIAL1] = serial1_request;
    assign hw_src[`VRC_CH_PWM] = pwm_request;
    assign hw_src[`VRC_CH_TWI] = twi_request;
    assign hw_src[`VRC_CH_SYNC0] = sync0_request;
    assign hw_src[`VRC_CH_SYNC1] = sync1_request;
    assign hw_src[`VRC_CH_PLL] = pll_locked_flag;
    assign hw_src[`VRC_CH_RTC] = rtc_request;
    assign hw_src[`VRC_CH_EXT0 + 0] = external_irq_zero;
    assign hw_src[`VRC_CH_EXT0 + 1] = external_irq_one;
    assign hw_src[`VRC_CH_EXT0 + 2] = external_irq_two;
    assign hw_src[`VRC_CH_EXT0 + 3] = external_irq_three;
    assign hw_src[`VRC_CH_ADC] = adc_request;
    assign hw_src[`VRC_CH_CAN_FILT] = can_filter_request;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_can
            assign hw_src[`VRC_CH_CAN0 + 2*g] = can_tx_request[g];
            assign hw_src[`VRC_CH_CAN0 + 2*g + 1] = can_rx_request[g];
        end
    endgenerate
    assign hw_src[NCH-1:28] = {(NCH-28){1'b0}};

    assign raw_req = hw_src | soft_r;
    assign fast_stat = raw_req & enable_r & select_r;
    assign norm_stat = raw_req & enable_r & ~select_r;

    generate
        for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
            assign slot_req[g] = slot_ctrl_r[g][`VRC_SLOT_EN_BIT] &
                norm_stat[slot_ctrl_r[g][`VRC_SLOT_SRC_MSB:`VRC_SLOT_SRC_LSB]];
        end
    endgenerate

    vrc_prio #(
        .NSLOT(NSLOT),
        .IW(SIW)
    ) u_prio (
        .slot_req(slot_req),
        .hit(slot_hit),
        .idx(slot_idx)
    );

    // unslotted requests only reach the default
    assign vect_addr = slot_hit ? slot_addr_r[slot_idx] : def_addr_r;

    assign addr_ok = hsel & hready & htrans[1];
    assign a_ofs = haddr[11:0];

    // read data is formed in the address phase and stands from a flop
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (a_ofs == `VRC_OFS_IRQ_STAT) begin
            rdata_nxt = norm_stat;
        end else if (a_ofs == `VRC_OFS_FAST_STAT) begin
            rdata_nxt = fast_stat;
        end else if (a_ofs == `VRC_OFS_RAW_STAT) begin
            rdata_nxt = raw_req;
        end else if (a_ofs == `VRC_OFS_ENABLE) begin
            rdata_nxt = enable_r;
        end else if (a_ofs == `VRC_OFS_SELECT) begin
            rdata_nxt = select_r;
        end else if (a_ofs == `VRC_OFS_SOFT) begin
            rdata_nxt = soft_r;
        end else if (a_ofs == `VRC_OFS_VECT_ADDR) begin
            rdata_nxt = vect_addr;
        end else if (a_ofs == `VRC_OFS_DEF_ADDR) begin
            rdata_nxt = def_addr_r;
        end else if (a_ofs[11:8] == `VRC_OFS_SLOT_ADDR &&
                     a_ofs[7:6] == 2'b00) begin
            rdata_nxt = slot_addr_r[a_ofs[5:2]];
        end else if (a_ofs[11:8] == `VRC_OFS_SLOT_CTRL &&
                     a_ofs[7:6] == 2'b00) begin
            rdata_nxt = {26'h0, slot_ctrl_r[a_ofs[5:2]]};
        end
    end

    // bus slave: zero wait states, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_r <= a_ofs;
            end
            if (addr_ok & ~hwrite) begin
                hrdata <= rdata_nxt;
            end
        end
    end

    // write strobes from the offset held since the address phase
    always @* begin
        we_enable = 1'b0;
        we_select = 1'b0;
        we_soft = 1'b0;
        we_def_addr = 1'b0;
        we_slot_addr = 1'b0;
        we_slot_ctrl = 1'b0;
        if (!wr_pend_r) begin
            we_enable = 1'b0;
        end else if (wr_addr_r == `VRC_OFS_ENABLE) begin
            we_enable = 1'b1;
        end else if (wr_addr_r == `VRC_OFS_SELECT) begin
            we_select = 1'b1;
        end else if (wr_addr_r == `VRC_OFS_SOFT) begin
            we_soft = 1'b1;
        end else if (wr_addr_r == `VRC_OFS_DEF_ADDR) begin
            we_def_addr = 1'b1;
        end else if (wr_addr_r[11:8] == `VRC_OFS_SLOT_ADDR &&
                     wr_addr_r[7:6] == 2'b00) begin
            we_slot_addr = 1'b1;
        end else if (wr_addr_r[11:8] == `VRC_OFS_SLOT_CTRL &&
                     wr_addr_r[7:6] == 2'b00) begin
            we_slot_ctrl = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= `VRC_RST_ENABLE;
        end else if (we_enable) begin
            enable_r <= hwdata;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_r <= `VRC_RST_SELECT;
        end else if (we_select) begin
            select_r <= hwdata;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_r <= `VRC_RST_SOFT;
        end else if (we_soft) begin
            soft_r <= hwdata;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            def_addr_r <= `VRC_RST_DEF_ADDR;
        end else if (we_def_addr) begin
            def_addr_r <= hwdata;
        end
    end

    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (k = 0; k < NSLOT; k = k + 1) begin
                slot_addr_r[k] <= `VRC_RST_SLOT_ADDR;
                slot_ctrl_r[k] <= `VRC_RST_SLOT_CTRL;
            end
        end else if (we_slot_addr) begin
            slot_addr_r[wr_addr_r[5:2]] <= hwdata;
        end else if (we_slot_ctrl) begin
            slot_ctrl_r[wr_addr_r[5:2]] <= hwdata[5:0];
        end
    end

    // outputs lag the requests by one clock to come from flops
    // fast OR
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_request_out <= 1'b0;
        end else begin
            fast_request_out <= |fast_stat;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            normal_request_out <= 1'b0;
        end else begin
            normal_request_out <= |norm_stat;
        end
    end
endmodule // vrc_ctrl

// >>> bench/vrc_core_model.sv
`timescale 1ns/1ps
// the core takes fast over normal when both lines stand
module vrc_core_model (
    input wire hclk,
    input wire hresetn,
    input wire fast_request_out,
    input wire normal_request_out,
    output reg [1:0] svc_r
);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) svc_r <= 2'h0;
        else svc_r <= fast_request_out ? 2'h2 :
            (normal_request_out ? 2'h1 : 2'h0);
    end
endmodule // vrc_core_model

// >>> bench/vrc_ctrl_asserts.sv
`timescale 1ns/1ps
module vrc_ctrl_asserts (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire fast_request_out,
    input wire normal_request_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire [11:0] a = haddr[11:0];
    a_ready_high: assert property (hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_fast_or: assert property (
        rd && a == 12'h004 |=> fast_request_out == |hrdata)
        else $error("fast line differs from fast status");
    a_normal_or: assert property (
        rd && a == 12'h000 |=> normal_request_out == |hrdata)
        else $error("normal line differs from normal status");
    a_slot_upper: assert property (
        rd && a[11:6] == 6'h08 |=> hrdata[31:6] == 26'h0)
        else $error("slot control upper bits set");
    a_hole_zero: assert property (
        rd && a >= 12'h018 && a <= 12'h02c |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(hresetn) |->
        !fast_request_out && !normal_request_out && hrdata == 32'h0)
        else $error("outputs active out of reset");
endmodule // vrc_ctrl_asserts
bind vrc_ctrl vrc_ctrl_asserts vrc_ctrl_asserts_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .fast_request_out, .normal_request_out);

// >>> bench/vrc_ctrl_tb.sv
`timescale 1ns/1ps
`include "vrc_regs.vh"
module vrc_ctrl_tb;
    reg hclk;
    reg hresetn;
    reg [31:0] haddr;
    reg [1:0] htrans;
    reg hwrite;
    reg [31:0] hwdata;
    reg [27:0] src;
    wire [31:0] hrdata;
    wire hreadyout;
    wire fast_request_out;
    wire normal_request_out;
    wire [1:0] svc;
    integer num_errors;
    integer checked;
    integer i;
    reg [31:0] q;
    vrc_ctrl vrc_ctrl_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp(), .watchdog_flag(src[0]),
        .debug_comm_receive(src[2]), .debug_comm_transmit(src[3]),
        .timer0_request(src[4]), .timer1_request(src[5]),
        .serial0_request(src[6]), .serial1_request(src[7]),
        .pwm_request(src[8]), .twi_request(src[9]), .sync0_request(src[10]),
        .sync1_request(src[11]), .pll_locked_flag(src[12]),
        .rtc_request(src[13]), .external_irq_zero(src[14]),
        .external_irq_one(src[15]), .external_irq_two(src[16]),
        .external_irq_three(src[17]), .adc_request(src[18]),
        .can_filter_request(src[19]),
        .can_tx_request({src[26], src[24], src[22], src[20]}),
        .can_rx_request({src[27], src[25], src[23], src[21]}),
        .fast_request_out, .normal_request_out);
    vrc_core_model vrc_core_model_i (.hclk, .hresetn, .fast_request_out,
        .normal_request_out, .svc_r(svc));
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // called just after a rising edge, returns on the data-phase edge
    task xfer(input [11:0] a, input w, input [31:0] d);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rdc(input [11:0] a, input [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask
    // output lands one edge late, the core sample one more
    task outs(input [1:0] e, input [1:0] s);
        repeat (3) @(posedge hclk);
        chk({30'h0, fast_request_out, normal_request_out}, {30'h0, e});
        chk({30'h0, svc}, {30'h0, s});
    endtask
    task slot(input [3:0] n, input [4:0] ch);
        xfer(12'h100 + {6'h0, n, 2'h0}, 1'b1, 32'ha000_0000 + n);
        xfer(12'h200 + {6'h0, n, 2'h0}, 1'b1, {26'h0, 1'b1, ch});
    endtask
    task print_verdict;
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #100000;
        num_errors = num_errors + 1;
        print_verdict;
    end
    initial begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        src = 28'h0;
        num_errors = 0;
        checked = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 16; i = i + 1) begin
            if (i < 15) rdc(12'(i * 4), 32'h0);
            rdc(12'(256 + i * 4), 32'h0);
            rdc(12'(512 + i * 4), 32'h0);
        end
        xfer(`VRC_OFS_ENABLE, 1'b1, 32'hffff_ffff);
        for (i = 0; i < 28; i = i + 1) begin
            src <= 28'h1 << i;
            outs(i == 1 ? 2'h0 : 2'h1, i == 1 ? 2'h0 : 2'h1);
            rdc(`VRC_OFS_RAW_STAT, i == 1 ? 32'h0 : 32'h1 << i);
            rdc(`VRC_OFS_IRQ_STAT, i == 1 ? 32'h0 : 32'h1 << i);
        end
        src <= 28'h20;
        rdc(`VRC_OFS_RAW_STAT, 32'h20);
        src <= 28'h80;
        rdc(`VRC_OFS_RAW_STAT, 32'h80);
        src <= 28'h1000;
        rdc(`VRC_OFS_RAW_STAT, 32'h1000);
        src <= 28'h2_0000;
        rdc(`VRC_OFS_RAW_STAT, 32'h2_0000);
        src <= 28'h800_0000;
        rdc(`VRC_OFS_RAW_STAT, 32'h800_0000);
        src <= 28'h0;
        outs(2'h0, 2'h0);
        xfer(`VRC_OFS_SOFT, 1'b1, 32'h2);
        outs(2'h1, 2'h1);
        rdc(`VRC_OFS_RAW_STAT, 32'h2);
        xfer(`VRC_OFS_SOFT, 1'b1, 32'h0);
        xfer(`VRC_OFS_SELECT, 1'b1, 32'h10);
        src <= 28'h50;
        outs(2'h3, 2'h2);
        rdc(`VRC_OFS_FAST_STAT, 32'h10);
        rdc(`VRC_OFS_IRQ_STAT, 32'h40);
        xfer(`VRC_OFS_ENABLE, 1'b1, 32'hffff_ffef);
        outs(2'h1, 2'h1);
        xfer(`VRC_OFS_ENABLE, 1'b1, 32'hffff_ffff);
        xfer(`VRC_OFS_DEF_ADDR, 1'b1, 32'hd000_0000);
        slot(4'h0, 5'd14);
        slot(4'hf, 5'd0);
        slot(4'h1, 5'd4);
        rdc(12'h23c, 32'h20);
        src <= 28'h4011;
        outs(2'h3, 2'h2);
        rdc(`VRC_OFS_VECT_ADDR, 32'ha000_0000);
        src <= 28'h11;
        outs(2'h3, 2'h2);
        rdc(`VRC_OFS_VECT_ADDR, 32'ha000_000f);
        src <= 28'h40010;
        outs(2'h3, 2'h2);
        rdc(`VRC_OFS_VECT_ADDR, 32'hd000_0000);
        src <= 28'h0;
        outs(2'h0, 2'h0);
        print_verdict;
    end
endmodule // vrc_ctrl_tb
